/* File: rtl/cas_pkg.sv */
package cas_pkg;

  // Clock rate and stabilisation delay
  localparam int unsigned CLK_FREQ_HZ   = 40_000_000;
  localparam int unsigned STAB_TIME_MS  = 10;
  localparam int unsigned STAB_CYCLES   = CLK_FREQ_HZ / 1000 * STAB_TIME_MS;
  localparam int unsigned RELEASE_EDGES = 42000;

  // Counter widths
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned STAB_W  = 20;
  localparam int unsigned EDGE_W  = 16;

  // Default length of each activation and deactivation interval
  localparam logic [TIMER_W-1:0] INTERVAL_DEFAULT = 16'h0050;

  // Positions of the synchronised pin inputs
  localparam int unsigned IN_W         = 11;
  localparam int unsigned IN_SESSION_N = 0;
  localparam int unsigned IN_VOLT_SEL  = 1;
  localparam int unsigned IN_PDOWN     = 2;
  localparam int unsigned IN_RST_REQ   = 3;
  localparam int unsigned IN_PRESENT   = 4;
  localparam int unsigned IN_DIV_LOW   = 5;
  localparam int unsigned IN_DIV_HIGH  = 6;
  localparam int unsigned IN_OCP       = 7;
  localparam int unsigned IN_OTP       = 8;
  localparam int unsigned IN_VDD_FAULT = 9;
  localparam int unsigned IN_VCC_FAULT = 10;
  localparam logic [IN_W-1:0] SYNC_RESET = 11'h001;

  // Divider select codes and half periods in input clock cycles
  localparam logic [1:0] DIV_BY_8 = 2'h0;
  localparam logic [1:0] DIV_BY_1 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV_BY_2 = 2'h3;
  localparam logic [2:0] HALF_DIV8 = 3'h4;
  localparam logic [2:0] HALF_DIV4 = 3'h2;
  localparam logic [2:0] HALF_DIV2 = 3'h1;

  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_SUPPLY = 10'h002,
    ST_IO     = 10'h004,
    ST_CLOCK  = 10'h008,
    ST_RESET  = 10'h010,
    ST_ACTIVE = 10'h020,
    ST_DE_RST = 10'h040,
    ST_DE_CLK = 10'h080,
    ST_DE_IO  = 10'h100,
    ST_DE_VCC = 10'h200
  } cas_seq_type;

  // Complete state of the sequencer
  typedef struct packed {
    logic [IN_W-1:0]    sync1;
    logic [IN_W-1:0]    sync2;
    logic               prev_session_n;
    cas_seq_type        seq;
    logic [TIMER_W-1:0] timer;
    logic [STAB_W-1:0]  stab;
    logic               rst_high_start;
    logic               fault;
    logic               supply_enable;
    logic               select_5v;
    logic               io_reception;
    logic               clock_run;
    logic               clock_phase;
    logic               clock_bypass;
    logic [2:0]         div_cnt;
    logic [EDGE_W-1:0]  edge_cnt;
    logic               card_reset;
    logic               interrupt_n;
    logic               low_power;
  } cas_state_type;

  localparam cas_state_type RESET_STATE = '{
    sync1:          SYNC_RESET,
    sync2:          SYNC_RESET,
    prev_session_n: 1'b1,
    seq:            ST_IDLE,
    timer:          16'h0000,
    stab:           20'h00000,
    rst_high_start: 1'b0,
    fault:          1'b0,
    supply_enable:  1'b0,
    select_5v:      1'b0,
    io_reception:   1'b0,
    clock_run:      1'b0,
    clock_phase:    1'b0,
    clock_bypass:   1'b0,
    div_cnt:        3'h0,
    edge_cnt:       16'h0000,
    card_reset:     1'b0,
    interrupt_n:    1'b0,
    low_power:      1'b0
  };

endpackage

/* File: rtl/cas_sequencer.sv */
`timescale 1ns/10ps

module cas_sequencer #(
  parameter logic [cas_pkg::TIMER_W-1:0] T1_CYCLES = cas_pkg::INTERVAL_DEFAULT,
  parameter logic [cas_pkg::TIMER_W-1:0] T2_CYCLES = cas_pkg::INTERVAL_DEFAULT,
  parameter logic [cas_pkg::TIMER_W-1:0] T3_CYCLES = cas_pkg::INTERVAL_DEFAULT,
  parameter logic [cas_pkg::TIMER_W-1:0] T4_CYCLES = cas_pkg::INTERVAL_DEFAULT,
  parameter logic [cas_pkg::STAB_W-1:0]  STAB_CYCLES =
    cas_pkg::STAB_W'(cas_pkg::STAB_CYCLES),
  parameter logic [cas_pkg::EDGE_W-1:0]  RELEASE_EDGES =
    cas_pkg::EDGE_W'(cas_pkg::RELEASE_EDGES)
) (
  // Clock and supply supervisor reset
  input  wire logic clk,
  input  wire logic resetn,
  // Host control pins
  input  wire logic session_request_n,
  input  wire logic card_voltage_select,
  input  wire logic power_down_request,
  input  wire logic card_reset_request,
  input  wire logic clock_divider_sel_low,
  input  wire logic clock_divider_sel_high,
  // Card presence and protection detectors
  input  wire logic card_present_input,
  input  wire logic over_current,
  input  wire logic over_temperature,
  input  wire logic digital_supply_fault,
  input  wire logic card_supply_fault,
  // Host interrupt
  output logic      interrupt_n,
  // Converter and analog control
  output logic      supply_enable,
  output logic      supply_select_5v,
  output logic      low_power_state,
  // Card contacts control
  output logic      io_reception,
  output logic      card_clock,
  output logic      card_clock_bypass,
  output logic      card_reset
);

  cas_pkg::cas_state_type r;
  cas_pkg::cas_state_type next_r;

  // Synchronised pin levels
  logic                       s_session_n;
  logic                       s_pdown;
  logic                       s_rst_req;
  logic                       s_present;
  logic                       s_vdd_fault;
  logic                       s_vcc_fault;
  logic [1:0]                 s_div;
  logic                       session_fall;
  logic                       blocked;
  logic                       in_session;
  logic                       supply_checked;
  logic                       fault_now;
  logic                       interval_done;
  logic [cas_pkg::TIMER_W-1:0] interval;
  logic [2:0]                 half;

  assign s_session_n = r.sync2[cas_pkg::IN_SESSION_N];
  assign s_pdown     = r.sync2[cas_pkg::IN_PDOWN];
  assign s_rst_req   = r.sync2[cas_pkg::IN_RST_REQ];
  assign s_present   = r.sync2[cas_pkg::IN_PRESENT];
  assign s_vdd_fault = r.sync2[cas_pkg::IN_VDD_FAULT];
  assign s_vcc_fault = r.sync2[cas_pkg::IN_VCC_FAULT];
  assign s_div       = {r.sync2[cas_pkg::IN_DIV_HIGH],
                        r.sync2[cas_pkg::IN_DIV_LOW]};

  // Session edge and blocking window
  assign session_fall = r.prev_session_n & ~s_session_n;
  assign blocked      = s_pdown | s_vdd_fault | (r.stab != '0);

  // Session membership and fault collection
  assign in_session = (r.seq == cas_pkg::ST_SUPPLY) |
                      (r.seq == cas_pkg::ST_IO) |
                      (r.seq == cas_pkg::ST_CLOCK) |
                      (r.seq == cas_pkg::ST_RESET) |
                      (r.seq == cas_pkg::ST_ACTIVE);
  assign supply_checked = in_session & (r.seq != cas_pkg::ST_SUPPLY);
  assign fault_now = in_session &
                     (r.sync2[cas_pkg::IN_OCP] |
                      r.sync2[cas_pkg::IN_OTP] |
                      s_vdd_fault |
                      (s_vcc_fault & supply_checked) |
                      ~s_present);

  // Interval length for the current step
  always_comb begin
    case (r.seq)
      cas_pkg::ST_SUPPLY,
      cas_pkg::ST_DE_RST: interval = T1_CYCLES;
      cas_pkg::ST_IO,
      cas_pkg::ST_DE_CLK: interval = T2_CYCLES;
      cas_pkg::ST_CLOCK,
      cas_pkg::ST_DE_IO:  interval = T3_CYCLES;
      default:            interval = T4_CYCLES;
    endcase
  end

  assign interval_done = (r.timer >= interval - 16'h0001);

  // Divider half period per select code
  always_comb begin
    case (s_div)
      cas_pkg::DIV_BY_8: half = cas_pkg::HALF_DIV8;
      cas_pkg::DIV_BY_4: half = cas_pkg::HALF_DIV4;
      cas_pkg::DIV_BY_2: half = cas_pkg::HALF_DIV2;
      default:           half = cas_pkg::HALF_DIV2;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_r = r;
    next_r.sync1 = {card_supply_fault, digital_supply_fault,
                    over_temperature, over_current,
                    clock_divider_sel_high, clock_divider_sel_low,
                    card_present_input, card_reset_request,
                    power_down_request, card_voltage_select,
                    session_request_n};
    next_r.sync2 = r.sync1;
    next_r.prev_session_n = s_session_n;
    next_r.select_5v = r.sync2[cas_pkg::IN_VOLT_SEL];
    next_r.low_power = s_pdown;

    // Blocking delay reloads while power-down or digital supply fault holds
    if (s_pdown | s_vdd_fault) begin
      next_r.stab = STAB_CYCLES;
    end else if (r.stab != '0) begin
      next_r.stab = r.stab - 20'h00001;
    end

    // Interval timer saturates
    if (r.timer != '1) begin
      next_r.timer = r.timer + 16'h0001;
    end

    case (r.seq)
      cas_pkg::ST_IDLE: begin
        if (session_fall & ~blocked & r.interrupt_n) begin
          next_r.seq = cas_pkg::ST_SUPPLY;
          next_r.timer = '0;
          next_r.supply_enable = 1'b1;
          next_r.rst_high_start = s_rst_req;
          next_r.fault = 1'b0;
        end
      end
      cas_pkg::ST_SUPPLY: begin
        if (interval_done) begin
          next_r.timer = '0;
          if (s_vcc_fault) begin
            next_r.fault = 1'b1;
            next_r.supply_enable = 1'b0;
            next_r.seq = cas_pkg::ST_IDLE;
          end else begin
            next_r.seq = cas_pkg::ST_IO;
          end
        end
      end
      cas_pkg::ST_IO: begin
        if (interval_done & ~(r.rst_high_start & s_rst_req)) begin
          next_r.io_reception = 1'b1;
          next_r.seq = cas_pkg::ST_CLOCK;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_CLOCK: begin
        if (interval_done) begin
          next_r.clock_run = 1'b1;
          next_r.edge_cnt = '0;
          next_r.seq = cas_pkg::ST_RESET;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_RESET: begin
        if (interval_done) begin
          next_r.seq = cas_pkg::ST_ACTIVE;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_ACTIVE: begin
        next_r.card_reset = s_rst_req &
                            (r.edge_cnt >= RELEASE_EDGES);
      end
      cas_pkg::ST_DE_RST: begin
        if (interval_done) begin
          next_r.card_reset = 1'b0;
          next_r.seq = cas_pkg::ST_DE_CLK;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_DE_CLK: begin
        if (interval_done) begin
          next_r.clock_run = 1'b0;
          next_r.seq = cas_pkg::ST_DE_IO;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_DE_IO: begin
        if (interval_done) begin
          next_r.io_reception = 1'b0;
          next_r.seq = cas_pkg::ST_DE_VCC;
          next_r.timer = '0;
        end
      end
      cas_pkg::ST_DE_VCC: begin
        if (interval_done) begin
          next_r.supply_enable = 1'b0;
          next_r.seq = cas_pkg::ST_IDLE;
          next_r.timer = '0;
        end
      end
      default: begin
        next_r.seq = cas_pkg::ST_IDLE;
        next_r.supply_enable = 1'b0;
        next_r.io_reception = 1'b0;
        next_r.clock_run = 1'b0;
        next_r.card_reset = 1'b0;
      end
    endcase

    // Host release or any fault other than a card supply fault in ST_SUPPLY overrides the activation steps
    if (in_session & (s_session_n | fault_now)) begin
      next_r.seq = cas_pkg::ST_DE_RST;
      next_r.timer = '0;
      next_r.card_reset = r.card_reset;
      if (fault_now) begin
        next_r.fault = 1'b1;
      end
    end

    // Fault flag clears only once the host has left the session
    if ((r.seq == cas_pkg::ST_IDLE) & s_session_n) begin
      next_r.fault = 1'b0;
    end

    // Card clock divider; held low from the edge that stops it
    if (!r.clock_run || !next_r.clock_run) begin
      next_r.clock_phase = 1'b0;
      next_r.div_cnt = '0;
    end else if (s_div == cas_pkg::DIV_BY_1) begin
      next_r.clock_phase = 1'b0;
      next_r.div_cnt = '0;
      if (r.edge_cnt != '1) begin
        next_r.edge_cnt = r.edge_cnt + 16'h0001;
      end
    end else if (r.div_cnt >= half - 3'h1) begin
      next_r.div_cnt = '0;
      next_r.clock_phase = ~r.clock_phase;
      if (!r.clock_phase && r.edge_cnt != '1) begin
        next_r.edge_cnt = r.edge_cnt + 16'h0001;
      end
    end else begin
      next_r.div_cnt = r.div_cnt + 3'h1;
    end
    next_r.clock_bypass = next_r.clock_run &
                          (s_div == cas_pkg::DIV_BY_1);

    // Interrupt: presence outside a session, faults inside
    next_r.interrupt_n = s_present & ~next_r.fault &
                         (s_pdown |
                          (~s_vdd_fault & (r.stab == '0)));
  end

  // State register, initialised by the supply supervisor reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= cas_pkg::RESET_STATE;
      r.stab <= STAB_CYCLES;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign interrupt_n       = r.interrupt_n;
  assign supply_enable     = r.supply_enable;
  assign supply_select_5v  = r.select_5v;
  assign low_power_state   = r.low_power;
  assign io_reception      = r.io_reception;
  assign card_clock        = r.clock_phase;
  assign card_clock_bypass = r.clock_bypass;
  assign card_reset        = r.card_reset;

endmodule

/* File: dv/cas_seq_checker.sv */
`timescale 1ns/10ps

module cas_seq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host pins and detectors
  input wire logic session_request_n,
  input wire logic card_voltage_select,
  input wire logic power_down_request,
  input wire logic card_present_input,
  input wire logic over_current,
  // Outputs of the sequencer
  input wire logic interrupt_n,
  input wire logic supply_enable,
  input wire logic supply_select_5v,
  input wire logic low_power_state,
  input wire logic io_reception,
  input wire logic card_clock,
  input wire logic card_clock_bypass,
  input wire logic card_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Copy, ordering and fault checks
  a_volt_copy: assert property (
    $stable(card_voltage_select)[*5] |->
      supply_select_5v == card_voltage_select)
    else $error("voltage select not copied");
  a_pdown_copy: assert property (
    $stable(power_down_request)[*5] |->
      low_power_state == power_down_request)
    else $error("low power state not following request");
  a_pd_blocks: assert property (low_power_state |-> !supply_enable)
    else $error("supply on in power down");
  a_fault_int_low: assert property (
    $rose(over_current) && io_reception && !session_request_n
      |-> ##[1:5] !interrupt_n)
    else $error("over current not reported");
  a_start_needs_card: assert property (
    $rose(supply_enable) |-> interrupt_n && !session_request_n)
    else $error("activation without card or request");
  a_supply_first: assert property (
    $rose(supply_enable) |-> !io_reception && !card_clock && !card_reset)
    else $error("supply not first");
  a_clock_order: assert property (
    (card_clock || card_clock_bypass) |-> io_reception && supply_enable)
    else $error("card clock before reception");
  a_reset_order: assert property (card_reset |-> io_reception)
    else $error("card reset outside session");
  a_deact_order: assert property (
    $fell(io_reception) |->
      !card_clock && !card_clock_bypass && !card_reset && supply_enable)
    else $error("deactivation out of order");
  a_int_presence: assert property (
    !card_present_input[*5] |-> !interrupt_n)
    else $error("interrupt high without card");

  // Main scenarios
  c_reset_high: cover property ($rose(card_reset));
  c_bypass: cover property ($rose(card_clock_bypass));
  c_deact: cover property ($fell(supply_enable));
  c_int_rise: cover property ($rose(interrupt_n));
endmodule

bind cas_sequencer cas_seq_checker u_chk (.clk, .resetn, .session_request_n,
  .card_voltage_select, .power_down_request, .card_present_input,
  .over_current, .interrupt_n, .supply_enable, .supply_select_5v,
  .low_power_state, .io_reception, .card_clock, .card_clock_bypass,
  .card_reset);

/* File: dv/cas_card_model.sv */
`timescale 1ns/10ps

module cas_card_model (
  // Clock and card contacts
  input  wire logic        clk,
  input  wire logic        supply_enable,
  input  wire logic        card_clock,
  input  wire logic        card_clock_bypass,
  // Scenario controls
  input  wire logic        inserted,
  input  wire logic        bad_supply,
  // Detector outputs and delivered edge count
  output logic             card_present_input,
  output logic             card_supply_fault,
  output logic [15:0]      edges
);
  logic [1:0] ramp     = 2'h0;
  logic       clk_prev = 1'b0;

  assign card_present_input = inserted;
  // Card supply valid two cycles after the converter starts
  assign card_supply_fault = (ramp != 2'h2);
  initial edges = 16'h0000;

  // Supply ramp and count of edges delivered to the card
  always @(posedge clk) begin
    clk_prev <= card_clock;
    if (!supply_enable || bad_supply) ramp <= 2'h0;
    else if (ramp != 2'h2) ramp <= ramp + 2'h1;
    if (!supply_enable) edges <= 16'h0000;
    else if (card_clock_bypass || (card_clock && !clk_prev))
      edges <= edges + 16'h0001;
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/10ps

module testbench;
  localparam int STAB = 50;
  typedef struct packed {
    logic [1:0] div;
    logic       volt;
    logic [2:0] half;
  } cas_row_type;
  cas_row_type rows [4] = '{'{2'h0, 1'b1, 3'h4}, '{2'h1, 1'b0, 3'h0},
                            '{2'h2, 1'b1, 3'h2}, '{2'h3, 1'b0, 3'h1}};
  logic clk = 1'b0, resetn = 1'b0, session_request_n = 1'b1;
  logic card_voltage_select = 1'b0, power_down_request = 1'b0;
  logic card_reset_request = 1'b0, over_current = 1'b0;
  logic clock_divider_sel_low = 1'b0, clock_divider_sel_high = 1'b0;
  logic over_temperature = 1'b0, digital_supply_fault = 1'b0;
  logic inserted = 1'b1, bad_supply = 1'b0;
  logic card_present_input, card_supply_fault, interrupt_n, supply_enable;
  logic supply_select_5v, low_power_state, io_reception, card_clock;
  logic card_clock_bypass, card_reset;
  logic [15:0] edges;
  int errors = 0, tests_run = 0, cycles = 0, n;

  // Supply check interval leaves room for the card supply ramp and sync
  cas_sequencer #(.T1_CYCLES(16'h0008), .T3_CYCLES(16'h0004),
    .T4_CYCLES(16'h0004), .STAB_CYCLES(20'h00032),
    .RELEASE_EDGES(16'h0014)) DUT (.*);
  cas_card_model u_card (.*);

  // Clock and hang limit
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_fault(input int k, input logic v);
    case (k)
      0: over_current <= v;
      1: over_temperature <= v;
      2: digital_supply_fault <= v;
      default: bad_supply <= v;
    endcase
  endtask
  task automatic wrap_up();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    tick(5);
    @(negedge clk);
    chk_bit(supply_enable | interrupt_n | card_reset, 1'b0);
    tick(1); resetn <= 1'b1;
    tick(10); session_request_n <= 1'b0;
    tick(20); @(negedge clk);
    chk_bit(interrupt_n, 1'b0);
    tick(1); session_request_n <= 1'b1;
    tick(8); @(negedge clk);
    chk_bit(supply_enable, 1'b0);
    do @(negedge clk); while (interrupt_n !== 1'b1);
    foreach (rows[i]) begin
      tick(1);
      {clock_divider_sel_high, clock_divider_sel_low} <= rows[i].div;
      card_voltage_select <= rows[i].volt;
      tick(6); session_request_n <= 1'b0;
      do @(negedge clk); while (supply_enable !== 1'b1);
      chk_bit(supply_select_5v, rows[i].volt);
      chk_bit(io_reception, 1'b0);
      do @(negedge clk); while (io_reception !== 1'b1);
      chk_bit(card_clock | card_clock_bypass, 1'b0);
      tick(1); card_reset_request <= 1'b1;
      if (rows[i].half == 3'h0) begin
        do @(negedge clk); while (card_clock_bypass !== 1'b1);
        chk_bit(card_clock, 1'b0);
      end else begin
        do @(negedge clk); while (card_clock !== 1'b1);
        n = 0;
        do begin @(negedge clk); n++; end while (card_clock === 1'b1);
        chk_cnt(16'(n), 16'(rows[i].half));
      end
      do @(negedge clk); while (card_reset !== 1'b1);
      chk_bit(edges >= 16'h0014, 1'b1);
      tick(1); session_request_n <= 1'b1;
      do @(negedge clk); while (card_reset !== 1'b0);
      chk_bit(io_reception & supply_enable, 1'b1);
      do @(negedge clk); while (io_reception !== 1'b0);
      chk_bit(card_clock | card_clock_bypass | ~supply_enable, 1'b0);
      do @(negedge clk); while (supply_enable !== 1'b0);
      tick(1); card_reset_request <= 1'b0;
    end
    // Reset request high when the session starts
    tick(1); card_reset_request <= 1'b1; session_request_n <= 1'b0;
    tick(30); @(negedge clk);
    chk_bit(supply_enable & ~io_reception, 1'b1);
    tick(1); card_reset_request <= 1'b0;
    do @(negedge clk); while (io_reception !== 1'b1);
    n = 0;
    do begin @(negedge clk); n++; end while (card_clock !== 1'b1);
    chk_bit(n >= 4 && n <= 6, 1'b1);
    // Each fault kind except card removal inside a session
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        tick(1); session_request_n <= 1'b0;
        do @(negedge clk); while (io_reception !== 1'b1);
      end
      tick(1); set_fault(k, 1'b1);
      do @(negedge clk); while (supply_enable !== 1'b0);
      chk_bit(interrupt_n | io_reception | card_reset, 1'b0);
      tick(1); set_fault(k, 1'b0); session_request_n <= 1'b1;
      do @(negedge clk); while (interrupt_n !== 1'b1);
    end
    // Card supply never becomes valid
    tick(1); bad_supply <= 1'b1; session_request_n <= 1'b0;
    do @(negedge clk); while (supply_enable !== 1'b1);
    n = 0;
    do begin @(negedge clk); n++; end while (supply_enable === 1'b1);
    // Supply stays on for exactly the first interval
    chk_bit(n == 8 && interrupt_n === 1'b0 && !io_reception, 1'b1);
    tick(1); bad_supply <= 1'b0; session_request_n <= 1'b1;
    do @(negedge clk); while (interrupt_n !== 1'b1);
    // Presence, power down and recovery
    tick(1); inserted <= 1'b0;
    tick(6); @(negedge clk);
    chk_bit(interrupt_n, 1'b0);
    tick(1); power_down_request <= 1'b1;
    tick(6); @(negedge clk);
    chk_bit(low_power_state, 1'b1);
    tick(1); inserted <= 1'b1;
    tick(6); @(negedge clk);
    chk_bit(interrupt_n, 1'b1);
    tick(1); session_request_n <= 1'b0;
    tick(10); @(negedge clk);
    chk_bit(supply_enable, 1'b0);
    tick(1); session_request_n <= 1'b1; power_down_request <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (interrupt_n !== 1'b0);
    do begin @(negedge clk); n++; end while (interrupt_n !== 1'b1);
    chk_bit(n >= STAB && n <= STAB + 8, 1'b1);
    // Fresh request after the window is honoured
    tick(1); session_request_n <= 1'b0;
    tick(4); @(negedge clk);
    chk_bit(supply_enable, 1'b1);
    wrap_up();
  end
endmodule
